// ===== hw/pwt_pkg.sv
`default_nettype none

package pwt_pkg;

  // ****************************************
  // Register map (index, byte address = 4 * index)
  // ****************************************
  localparam logic [9:0] IDX_LOWVOLT_CONTROL_STATUS = 10'h2f1;
  localparam logic [9:0] IDX_PERIODIC_TIMER_CONTROL = 10'h2f2;
  localparam logic [9:0] IDX_PERIODIC_TIMER_TRIM    = 10'h2f3;
  localparam logic [9:0] IDX_WAKE_PERIOD_RATE       = 10'h2f4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LV_STATUS_BIT  = 2;
  localparam int LV_IRQ_EN_BIT  = 1;
  localparam int LV_FLAG_BIT    = 0;
  localparam int TM_CLKSEL_BIT  = 7;
  localparam int TM_WFSEL_BIT   = 4;
  localparam int TM_OUTEN_BIT   = 3;
  localparam int TM_FEATEN_BIT  = 2;
  localparam int TM_IRQEN_BIT   = 1;
  localparam int TM_FLAG_BIT    = 0;
  localparam int TRIM_LSB       = 2;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [5:0]  TRIM_RESET      = 6'h00;
  localparam logic [15:0] RATE_RESET      = 16'h0000;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          OSC_TICK_NS     = 100000;
  localparam int          OSC_TICK_CYCLES = OSC_TICK_NS / CLK_PERIOD_NS;
  localparam int          TRIM_STEP_CYCLES = 16;
  localparam int          DIV_W           = 20;

  // ****************************************
  // State of the block
  // ****************************************
  typedef struct packed {
    logic              lvStatus;
    logic              lvFlag;
    logic              lvIrqEn;
    logic              clkSel;
    logic              wfSel;
    logic              outEn;
    logic              featEn;
    logic              tmIrqEn;
    logic              tmFlag;
    logic [5:0]        trim;
    logic [15:0]       rate;
    logic [DIV_W-1:0]  divCnt;
    logic [16:0]       perCnt;
    logic              pulse;
    logic              clkPhase;
    logic              wakeOut;
    logic              lvIrq;
    logic              tmIrq;
    logic              waitReq;
    logic [31:0]       rdData;
  } pwt_state_t;

endpackage

`default_nettype wire

// ===== hw/pwt_wakeup_timer.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RULE1: Status bit read-only, writes ignored
// RULE2: Status high only below threshold in full mode
// RULE3: Change flag sets on any status change
// RULE4: Change flag clears by writing one
// RULE5: Low-voltage interrupt equals flag and enable
// RULE6: Reduced power entry keeps change flag
// RULE7: Clock select picks oscillator or bus
// RULE8: Clock select writable only while disabled
// RULE9: Clock waveform at twice the period
// RULE10: Pulse waveform one tick each period
// RULE11: Output only when output and feature enabled
// RULE12: Feature enable starts the timer
// RULE13: Timer interrupt equals flag and enable
// RULE14: Timeout flag sets each elapsed period
// RULE15: Timeout flag clears by one, clear wins
// RULE16: Six-bit trim in upper bits, preset reset
// RULE17: Binary-weighted trim, top bit lengthens
// RULE18: Period is two times (rate plus one) ticks
// RULE19: Rate writable only while disabled
// RULE20: Count restarts each timeout, resets off
module pwt_wakeup_timer #(
  parameter int         OSC_TICK_CYCLES  = pwt_pkg::OSC_TICK_CYCLES,
  parameter int         TRIM_STEP_CYCLES = pwt_pkg::TRIM_STEP_CYCLES,
  parameter logic [5:0] TRIM_RESET       = pwt_pkg::TRIM_RESET
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        supplyBelowAssert,
  input  wire logic        supplyAboveDeassert,
  input  wire logic        fullPerfMode,
  output logic             lowVoltIrq,
  output logic             wakeTimerIrq,
  output logic             wakeOut
);

  // ****************************************
  // State registers
  // ****************************************
  pwt_pkg::pwt_state_t st_q;
  pwt_pkg::pwt_state_t st_d;

  function automatic logic hitIdx(input logic [11:0] a, input logic [9:0] idx);
    hitIdx = (a[11:2] == idx);
  endfunction

  localparam int DIVW = pwt_pkg::DIV_W;
  logic [DIVW-1:0] divLimit;

  // Trim moves the oscillator tick length; bit 5 weighs 32 steps,
  // the lower five subtract 16..1 steps so each is less than the next.
  always_comb begin
    divLimit = DIVW'(OSC_TICK_CYCLES)
             + (st_q.trim[5] ? DIVW'(32 * TRIM_STEP_CYCLES) : '0)  // RULE17
             - DIVW'(int'(st_q.trim[4:0]) * TRIM_STEP_CYCLES);      // RULE17
  end

  // ****************************************
  // Next state
  // ****************************************
  logic busReq;
  logic wrAct;
  logic tick;
  logic timeout;
  logic [DIVW-1:0] divNext;

  always_comb begin
    st_d    = st_q;
    busReq  = read | write;
    wrAct   = write & ~st_q.waitReq & byteenable[0];
    tick    = 1'b0;
    timeout = 1'b0;
    divNext = st_q.divCnt + DIVW'(1);

    // Low-voltage status with hysteresis between the two levels
    if (!fullPerfMode) begin
      st_d.lvStatus = 1'b0;  // RULE2
    end else if (supplyBelowAssert) begin
      st_d.lvStatus = 1'b1;  // RULE2
    end else if (supplyAboveDeassert) begin
      st_d.lvStatus = 1'b0;  // RULE2
    end

    // ****************************************
    // Register writes, taken when waitrequest is low
    // ****************************************
    if (wrAct && hitIdx(address, pwt_pkg::IDX_LOWVOLT_CONTROL_STATUS)) begin
      // Status bit is not written here
      st_d.lvIrqEn = writedata[pwt_pkg::LV_IRQ_EN_BIT];  // RULE1
      if (writedata[pwt_pkg::LV_FLAG_BIT]) begin
        st_d.lvFlag = 1'b0;  // RULE4
      end
    end
    if (wrAct && hitIdx(address, pwt_pkg::IDX_PERIODIC_TIMER_CONTROL)) begin
      if (!st_q.featEn && !writedata[pwt_pkg::TM_FEATEN_BIT]) begin
        st_d.clkSel = writedata[pwt_pkg::TM_CLKSEL_BIT];  // RULE8
      end
      st_d.wfSel   = writedata[pwt_pkg::TM_WFSEL_BIT];
      st_d.outEn   = writedata[pwt_pkg::TM_OUTEN_BIT];
      st_d.featEn  = writedata[pwt_pkg::TM_FEATEN_BIT];  // RULE12
      st_d.tmIrqEn = writedata[pwt_pkg::TM_IRQEN_BIT];
    end
    if (wrAct && hitIdx(address, pwt_pkg::IDX_PERIODIC_TIMER_TRIM)) begin
      st_d.trim = writedata[pwt_pkg::TRIM_LSB +: 6];  // RULE16
    end
    if (write && !st_q.waitReq && !st_q.featEn
        && hitIdx(address, pwt_pkg::IDX_WAKE_PERIOD_RATE)) begin
      if (byteenable[0]) begin
        st_d.rate[7:0] = writedata[7:0];  // RULE19
      end
      if (byteenable[1]) begin
        st_d.rate[15:8] = writedata[15:8];  // RULE19
      end
    end

    // Set wins over the software clear for the change flag
    if (st_d.lvStatus != st_q.lvStatus) begin
      st_d.lvFlag = 1'b1;  // RULE3 RULE6
    end

    // ****************************************
    // Period timer
    // ****************************************
    if (st_q.clkSel) begin
      tick = 1'b1;  // RULE7
    end else if (divNext >= divLimit) begin
      tick = 1'b1;  // RULE7
    end

    if (!st_d.featEn) begin
      st_d.divCnt   = '0;  // RULE20
      st_d.perCnt   = '0;  // RULE20
      st_d.pulse    = 1'b0;
      st_d.clkPhase = 1'b0;
    end else begin
      if (!st_q.clkSel) begin
        st_d.divCnt = tick ? '0 : divNext;
      end
      if (tick) begin
        st_d.pulse = 1'b0;
        if (st_q.perCnt == {st_q.rate, 1'b1}) begin
          timeout       = 1'b1;  // RULE18
          st_d.perCnt   = '0;  // RULE20
          st_d.pulse    = 1'b1;  // RULE10
          st_d.clkPhase = ~st_q.clkPhase;  // RULE9
        end else begin
          st_d.perCnt = st_q.perCnt + 17'h00001;  // RULE18
        end
      end
    end

    if (timeout) begin
      st_d.tmFlag = 1'b1;  // RULE14
    end
    // Clear has precedence over a coinciding timeout
    if (wrAct && hitIdx(address, pwt_pkg::IDX_PERIODIC_TIMER_CONTROL)
        && writedata[pwt_pkg::TM_FLAG_BIT]) begin
      st_d.tmFlag = 1'b0;  // RULE15
    end

    st_d.wakeOut = st_d.outEn & st_d.featEn  // RULE11
                 & (st_d.wfSel ? st_d.clkPhase : st_d.pulse);  // RULE9 RULE10
    st_d.lvIrq   = st_d.lvFlag & st_d.lvIrqEn;  // RULE5
    st_d.tmIrq   = st_d.tmFlag & st_d.tmIrqEn;  // RULE13

    // ****************************************
    // Bus answer: one wait cycle, then waitrequest low for one cycle
    // ****************************************
    if (busReq && st_q.waitReq) begin
      st_d.waitReq = 1'b0;
      st_d.rdData  = '0;
      if (hitIdx(address, pwt_pkg::IDX_LOWVOLT_CONTROL_STATUS)) begin
        st_d.rdData[pwt_pkg::LV_STATUS_BIT] = st_q.lvStatus;  // RULE1
        st_d.rdData[pwt_pkg::LV_IRQ_EN_BIT] = st_q.lvIrqEn;
        st_d.rdData[pwt_pkg::LV_FLAG_BIT]   = st_q.lvFlag;
      end else if (hitIdx(address, pwt_pkg::IDX_PERIODIC_TIMER_CONTROL)) begin
        st_d.rdData[pwt_pkg::TM_CLKSEL_BIT] = st_q.clkSel;
        st_d.rdData[pwt_pkg::TM_WFSEL_BIT]  = st_q.wfSel;
        st_d.rdData[pwt_pkg::TM_OUTEN_BIT]  = st_q.outEn;
        st_d.rdData[pwt_pkg::TM_FEATEN_BIT] = st_q.featEn;
        st_d.rdData[pwt_pkg::TM_IRQEN_BIT]  = st_q.tmIrqEn;
        st_d.rdData[pwt_pkg::TM_FLAG_BIT]   = st_q.tmFlag;
      end else if (hitIdx(address, pwt_pkg::IDX_PERIODIC_TIMER_TRIM)) begin
        st_d.rdData[pwt_pkg::TRIM_LSB +: 6] = st_q.trim;
      end else if (hitIdx(address, pwt_pkg::IDX_WAKE_PERIOD_RATE)) begin
        st_d.rdData[15:0] = st_q.rate;
      end
    end else begin
      st_d.waitReq = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q         <= '0;
      st_q.trim    <= TRIM_RESET;  // RULE16
      st_q.rate    <= pwt_pkg::RATE_RESET;
      st_q.waitReq <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign readdata     = st_q.rdData;
  assign waitrequest  = st_q.waitReq;
  assign lowVoltIrq   = st_q.lvIrq;
  assign wakeTimerIrq = st_q.tmIrq;
  assign wakeOut      = st_q.wakeOut;

  // ****************************************
  // Checks
  // ****************************************
  // Write strobes shared by the checks below
  logic hitLv;
  logic hitCt;
  logic clrLvFlag;
  logic clrTmFlag;
  logic rateWr;

  assign hitLv     = hitIdx(address, pwt_pkg::IDX_LOWVOLT_CONTROL_STATUS);
  assign hitCt     = hitIdx(address, pwt_pkg::IDX_PERIODIC_TIMER_CONTROL);
  assign clrLvFlag = wrAct & hitLv & writedata[pwt_pkg::LV_FLAG_BIT];
  assign clrTmFlag = wrAct & hitCt & writedata[pwt_pkg::TM_FLAG_BIT];
  assign rateWr    = write & ~st_q.waitReq & ~st_q.featEn
                   & hitIdx(address, pwt_pkg::IDX_WAKE_PERIOD_RATE);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_status_low_power: assert property (  // RULE2
    !fullPerfMode |=> !st_q.lvStatus)
    else $error("low-voltage status set outside full performance mode");

  a_change_flag_set: assert property (  // RULE3
    (st_q.lvStatus != $past(st_q.lvStatus)) |-> st_q.lvFlag)
    else $error("status change did not set change flag");

  a_lowvolt_irq_tie: assert property (  // RULE5
    lowVoltIrq == (st_q.lvFlag && st_q.lvIrqEn))
    else $error("low-voltage interrupt disagrees with flag and enable");

  a_clksel_locked: assert property (  // RULE8
    st_q.featEn |=> $stable(st_q.clkSel))
    else $error("clock select changed while timer enabled");

  a_rate_locked: assert property (  // RULE19
    st_q.featEn |=> $stable(st_q.rate))
    else $error("rate changed while timer enabled");

  a_output_gated: assert property (  // RULE11
    !(st_q.outEn && st_q.featEn) |-> !wakeOut)
    else $error("wake output active while not enabled");

  a_disabled_idle: assert property (  // RULE20
    !st_q.featEn |-> (st_q.perCnt == 17'h00000) && !st_q.pulse)
    else $error("period count running while disabled");

  a_bus_timeout_flag: assert property (  // RULE14
    (st_q.featEn && st_q.clkSel && $past(st_q.featEn)
     && $past(st_q.perCnt) == {st_q.rate, 1'b1}) |-> st_q.tmFlag || $past(wrAct))
    else $error("timeout did not set flag");

  a_bus_answer: assert property (
    (busReq && st_q.waitReq) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not given in one cycle");

  a_status_below_set: assert property (  // RULE2
    fullPerfMode && supplyBelowAssert |=> st_q.lvStatus)
    else $error("status not set below assert level");

  a_status_above_clear: assert property (  // RULE2
    fullPerfMode && !supplyBelowAssert && supplyAboveDeassert |=> !st_q.lvStatus)
    else $error("status not cleared above deassert level");

  a_status_hold: assert property (  // RULE1
    fullPerfMode && !supplyBelowAssert && !supplyAboveDeassert |=> $stable(st_q.lvStatus))
    else $error("status moved without a supply change");

  a_lv_flag_w0: assert property (  // RULE4
    wrAct && hitLv && !writedata[pwt_pkg::LV_FLAG_BIT] && st_q.lvFlag |=> st_q.lvFlag)
    else $error("writing zero cleared the change flag");

  a_lv_flag_clear: assert property (  // RULE4
    clrLvFlag ##1 $stable(st_q.lvStatus) |-> !st_q.lvFlag)
    else $error("writing one did not clear the change flag");

  a_lv_flag_hold: assert property (  // RULE6
    st_q.lvFlag && !clrLvFlag |=> st_q.lvFlag)
    else $error("change flag dropped without a clearing write");

  a_timer_irq_tie: assert property (  // RULE13
    wakeTimerIrq == (st_q.tmFlag && st_q.tmIrqEn))
    else $error("timer interrupt disagrees with flag and enable");

  a_tm_flag_clear: assert property (  // RULE15
    clrTmFlag |=> !st_q.tmFlag)
    else $error("timeout flag not cleared by writing one");

  a_tm_flag_hold: assert property (  // RULE15
    st_q.tmFlag && !clrTmFlag |=> st_q.tmFlag)
    else $error("timeout flag dropped without a clearing write");

  a_timeout_sets_flag: assert property (  // RULE14
    timeout && !clrTmFlag |=> st_q.tmFlag)
    else $error("elapsed period did not set timeout flag");

  a_clksel_same_write: assert property (  // RULE8
    wrAct && hitCt && writedata[pwt_pkg::TM_FEATEN_BIT] |=> $stable(st_q.clkSel))
    else $error("clock select changed by the enabling write");

  a_clksel_accept: assert property (  // RULE7
    wrAct && hitCt && !st_q.featEn && !writedata[pwt_pkg::TM_FEATEN_BIT]
    |=> st_q.clkSel == $past(writedata[pwt_pkg::TM_CLKSEL_BIT]))
    else $error("clock select write not taken while disabled");

  a_feature_enable: assert property (  // RULE12
    wrAct && hitCt |=> st_q.featEn == $past(writedata[pwt_pkg::TM_FEATEN_BIT]))
    else $error("feature enable does not follow the write");

  a_bus_clock_step: assert property (  // RULE7
    st_q.featEn && st_q.clkSel && !timeout
    |=> !st_q.featEn || st_q.perCnt == $past(st_q.perCnt) + 17'h00001)
    else $error("bus clock did not advance the period count");

  a_osc_tick_hold: assert property (  // RULE7
    st_q.featEn && !st_q.clkSel && divNext < divLimit
    |=> !st_q.featEn || $stable(st_q.perCnt))
    else $error("period count moved between oscillator ticks");

  a_pulse_on_timeout: assert property (  // RULE10
    timeout |=> st_q.pulse)
    else $error("no pulse at end of period");

  a_pulse_until_tick: assert property (  // RULE10
    st_q.pulse && !tick |=> st_q.pulse || !st_q.featEn)
    else $error("pulse ended before the next tick");

  a_pulse_ends: assert property (  // RULE10
    st_q.pulse && tick && !timeout |=> !st_q.pulse)
    else $error("pulse longer than one tick");

  a_phase_toggle: assert property (  // RULE9
    timeout |=> st_q.clkPhase != $past(st_q.clkPhase))
    else $error("clock waveform did not toggle at timeout");

  a_phase_steady: assert property (  // RULE9
    st_q.featEn && !timeout |=> !st_q.featEn || $stable(st_q.clkPhase))
    else $error("clock waveform toggled inside a period");

  a_output_select: assert property (  // RULE9
    wakeOut == (st_q.outEn && st_q.featEn && (st_q.wfSel ? st_q.clkPhase : st_q.pulse)))
    else $error("wake output does not show the selected waveform");

  a_rate_low_write: assert property (  // RULE19
    rateWr && byteenable[0] |=> st_q.rate[7:0] == $past(writedata[7:0]))
    else $error("rate low byte write not taken while disabled");

  a_rate_high_write: assert property (  // RULE19
    rateWr && byteenable[1] |=> st_q.rate[15:8] == $past(writedata[15:8]))
    else $error("rate high byte write not taken while disabled");

  a_trim_write: assert property (  // RULE16
    wrAct && hitIdx(address, pwt_pkg::IDX_PERIODIC_TIMER_TRIM)
    |=> st_q.trim == $past(writedata[pwt_pkg::TRIM_LSB +: 6]))
    else $error("trim write not taken");

  a_count_bound: assert property (  // RULE18
    st_q.perCnt <= {st_q.rate, 1'b1})
    else $error("period count beyond the rate value");

  a_count_restart: assert property (  // RULE20
    timeout |=> st_q.perCnt == 17'h00000)
    else $error("period count not restarted after timeout");

endmodule  // pwt_wakeup_timer

`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module tb;
  localparam logic [9:0] LV = pwt_pkg::IDX_LOWVOLT_CONTROL_STATUS;
  localparam logic [9:0] CT = pwt_pkg::IDX_PERIODIC_TIMER_CONTROL;
  localparam logic [9:0] TR = pwt_pkg::IDX_PERIODIC_TIMER_TRIM;
  localparam logic [9:0] RT = pwt_pkg::IDX_WAKE_PERIOD_RATE;
  logic        clk;
  logic        reset;
  logic [11:0] address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        supplyBelowAssert;
  logic        supplyAboveDeassert;
  logic        fullPerfMode;
  logic        lowVoltIrq;
  logic        wakeTimerIrq;
  logic        wakeOut;
  logic [31:0] expQ[$];
  logic [31:0] expV;
  int          mismatches;
  int          numChecks;

  // Divider shortened so an oscillator tick is 40 cycles, trim step 1 cycle
  pwt_wakeup_timer #(.OSC_TICK_CYCLES(40), .TRIM_STEP_CYCLES(1)) uut (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .supplyBelowAssert(supplyBelowAssert),
    .supplyAboveDeassert(supplyAboveDeassert), .fullPerfMode(fullPerfMode),
    .lowVoltIrq(lowVoltIrq), .wakeTimerIrq(wakeTimerIrq), .wakeOut(wakeOut));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic bail();
    mismatches++;
    final_report();
  endtask

  // Read answers are matched against the oldest note
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) begin
      if (expQ.size() == 0) begin
        bail();
      end else begin
        expV = expQ.pop_front();
        `CHK(readdata, expV)
      end
    end
  end

  // ****************************************
  // Bus and waveform helpers
  // ****************************************
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] d,
                     input logic [31:0] e);
    int k;
    @(posedge clk);
    if (!wr) expQ.push_back(e);
    address   <= {idx, 2'b00};
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    write <= 1'b0;
    read  <= 1'b0;
    if (k == 50) bail();
  endtask

  // Cycles until wakeOut reaches v; bounded so a dead timer cannot hang
  task automatic waitOut(input logic v, output int d);
    d = 0;
    do begin
      @(posedge clk);
      d++;
    end while (wakeOut !== v && d < 3000);
    if (d >= 3000) bail();
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    bail();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int r, t, d, lim;
    reset = 1'b1; address = '0; read = 1'b0; write = 1'b0; byteenable = 4'hf;
    writedata = '0; supplyBelowAssert = 1'b0; supplyAboveDeassert = 1'b1;
    fullPerfMode = 1'b1; mismatches = 0; numChecks = 0;
    void'($urandom(52763));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    bus(0, LV, 0, 32'h0);
    bus(0, CT, 0, 32'h0);
    bus(0, TR, 0, 32'h0);
    bus(0, 10'h2f6, 0, 32'h0);
    supplyAboveDeassert <= 1'b0;
    supplyBelowAssert   <= 1'b1;
    repeat (2) @(posedge clk);
    bus(0, LV, 0, 32'h5);
    `CHK(lowVoltIrq, 1'b0)
    bus(1, LV, 32'h6, 0);
    bus(0, LV, 0, 32'h7);
    `CHK(lowVoltIrq, 1'b1)
    bus(1, LV, 32'h3, 0);
    bus(0, LV, 0, 32'h6);
    fullPerfMode <= 1'b0;
    repeat (2) @(posedge clk);
    bus(0, LV, 0, 32'h3);
    `CHK(lowVoltIrq, 1'b1)
    bus(1, CT, 32'h84, 0);
    bus(0, CT, 0, 32'h4);
    bus(1, RT, 32'h5, 0);
    bus(0, RT, 0, 32'h0);
    bus(1, CT, 32'h0, 0);
    bus(1, CT, 32'h80, 0);
    bus(0, CT, 0, 32'h80);
    r = 1 + $urandom % 7;
    // Low lane only: the high byte must stay clear
    byteenable <= 4'h1;
    bus(1, RT, 32'hab00 | r, 0);
    byteenable <= 4'hf;
    bus(0, RT, 0, r);
    bus(1, CT, 32'h9e, 0);
    waitOut(1, d);
    waitOut(0, d);
    `CHK(d, 2 * (r + 1))
    waitOut(1, d);
    `CHK(d, 2 * (r + 1))
    `CHK(wakeTimerIrq, 1'b1)
    bus(1, CT, 32'h9d, 0);
    repeat (2) @(posedge clk);
    `CHK(wakeTimerIrq, 1'b0)
    bus(1, CT, 32'h01, 0);
    // Select was locked while enabled; clear it for the oscillator runs
    bus(0, CT, 0, 32'h80);
    bus(1, CT, 32'h00, 0);
    t = $urandom % 64;
    bus(1, TR, t << 2, 0);
    bus(0, TR, 0, t << 2);
    bus(1, RT, 0, 0);
    bus(1, CT, 32'h0c, 0);
    lim = 40 + (t >> 5) * 32 - (t & 31);
    waitOut(1, d);
    waitOut(0, d);
    `CHK(d, lim)
    waitOut(1, d);
    `CHK(d, lim)
    bus(0, CT, 0, 32'h0d);
    bus(1, CT, 32'h05, 0);
    repeat (2) @(posedge clk);
    d = 0;
    repeat (200) begin
      @(posedge clk);
      if (wakeOut !== 1'b0) d++;
    end
    `CHK(d, 0)
    bus(1, CT, 32'h01, 0);
    repeat (200) @(posedge clk);
    bus(0, CT, 0, 32'h0);
    final_report();
  end
endmodule // tb
`default_nettype wire
